/* File: core/btd_pkg.sv */
// Purpose: Shared constants for the backplane trigger debounce block.
// Assumes: Core clock aclk at 20 MHz; AXI4-Lite register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package btd_pkg;
	// ****************************************************************
	// Channel layout of the filtered vector.
	// ****************************************************************
	localparam int NCH       = 11;
	localparam int NTRIG     = 8;
	localparam int CH_STAR   = 8;
	localparam int CH_DSTARA = 9;
	localparam int CH_DSTARB = 10;

	// ****************************************************************
	// Filter settings and consecutive-sample counts.
	// ****************************************************************
	localparam logic [2:0]  FS_NONE   = 3'h0;
	localparam logic [2:0]  FS_SHORT  = 3'h1;
	localparam logic [2:0]  FS_MEDIUM = 3'h2;
	localparam logic [2:0]  FS_HIGH   = 3'h3;
	localparam logic [2:0]  FS_CUSTOM = 3'h4;
	localparam int          CNT_W     = 16;
	localparam logic [15:0] N_SHORT   = 16'h0009;
	localparam logic [15:0] N_MEDIUM  = 16'h0200;
	localparam logic [15:0] N_HIGH    = 16'h0100;

	// ****************************************************************
	// Timebases, in ns, and their dividers from aclk.
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int FAST_TB_NS    = 10;
	localparam int SLOW_TB_NS    = 10000;
	localparam int FAST_DIV_I    = (FAST_TB_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(FAST_TB_NS / CLK_PERIOD_NS);
	localparam int SLOW_DIV_I    = (SLOW_TB_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(SLOW_TB_NS / CLK_PERIOD_NS);
	localparam logic [15:0] FAST_DIV = 16'(FAST_DIV_I);
	localparam logic [15:0] SLOW_DIV = 16'(SLOW_DIV_I);

	// ****************************************************************
	// Register map.
	// ****************************************************************
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ROUTE  = 8'h04;
	localparam logic [7:0] OFS_CUST_N = 8'h08;
	localparam logic [7:0] OFS_CUST_D = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_PIO    = 8'h14;
	localparam logic [7:0] OFS_FILT0  = 8'h20;
	localparam logic [15:0] RST_CUST_N = 16'h0009;
	localparam logic [15:0] RST_CUST_D = 16'h0001;
	localparam logic [3:0]  SEL_SWLVL  = 4'hf;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

/* File: core/btd_tick_if.sv */
// Purpose: Carries filter timebase ticks and the custom count to filters.
// Assumes: All signals synchronous to aclk.
// Notes:   Ticks are one-cycle pulses; a divisor of one or zero holds the tick high every cycle.
`timescale 1ns/1ps
interface btd_tick_if;
	logic        tick_fast;
	logic        tick_slow;
	logic        tick_cust;
	logic [15:0] cust_n;
	modport src  (output tick_fast, output tick_slow, output tick_cust, output cust_n);
	modport sink (input tick_fast, input tick_slow, input tick_cust, input cust_n);
endinterface

/* File: core/btd_tick_div.sv */
// Purpose: Divides aclk into a one-cycle timebase tick.
// Assumes: A divisor of zero acts as one.
// Notes:   The count restarts whenever it reaches the divisor.
`timescale 1ns/1ps
module btd_tick_div
	import btd_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// Divisor and tick.
	input  wire logic [W-1:0] div,
	output logic              tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} btd_div_st_t;

	btd_div_st_t st_r;
	btd_div_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (st_r.cnt + W'(1) >= div) begin
			st_nxt.cnt  = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt  = st_r.cnt + W'(1);
			st_nxt.tick = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
endmodule

/* File: core/btd_filter.sv */
// Purpose: Debounce filter for one trigger input.
// Assumes: din is synchronous to aclk; ticks come from the tick interface.
// Notes:   The output flips after N consecutive samples at the new level.
`timescale 1ns/1ps
module btd_filter
	import btd_pkg::*;
(
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	// Setting and timebase.
	input  wire logic [2:0] setting,
	btd_tick_if.sink        tb,
	// Signal.
	input  wire logic       din,
	output logic            dout
);
	typedef struct packed {
		logic             level;
		logic [CNT_W-1:0] cnt;
		logic [2:0]       set_q;
	} btd_flt_st_t;

	btd_flt_st_t      st_r;
	btd_flt_st_t      st_nxt;
	logic [CNT_W-1:0] n;
	logic             tick;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.set_q = setting;
		n            = N_SHORT;
		tick         = tb.tick_fast;
		case (setting)
			FS_MEDIUM: begin
				n    = N_MEDIUM;
				tick = tb.tick_fast;
			end
			FS_HIGH: begin
				n    = N_HIGH;
				tick = tb.tick_slow;
			end
			FS_CUSTOM: begin
				n    = tb.cust_n;
				tick = tb.tick_cust;
			end
			default: begin
				n    = N_SHORT;
				tick = tb.tick_fast;
			end
		endcase
		if (setting != st_r.set_q) begin
			st_nxt.cnt = '0;
		end else if (setting == FS_NONE) begin
			st_nxt.level = din;
			st_nxt.cnt   = '0;
		end else if (tick) begin
			if (din == st_r.level) begin
				st_nxt.cnt = '0;
			end else if (st_r.cnt + CNT_W'(1) >= n) begin
				st_nxt.level = din;
				st_nxt.cnt   = '0;
			end else begin
				st_nxt.cnt = st_r.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '{level: 1'b0, cnt: '0, set_q: FS_NONE};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.level;
endmodule

/* File: core/btd_top.sv */
// Purpose: Backplane trigger input stage with per-line debounce filters.
// Assumes: AXI4-Lite slave on aclk; backplane inputs synchronous to aclk.
// Notes:   The 100 MHz timebase is stood in for by aclk ticks.
//
// Operation
// - Selectable filter per input; none bypasses
// - Sample once per filter clock tick
// - Rise after N consecutive high samples
// - Fall after N consecutive low samples
// - N is 9, 512, 256 or custom
// - Filter clock from oscillator per setting
// - Reject pulses shorter than the setting
// - Each input has its own setting
// - All filters disabled after reset
// - Added jitter at most one timebase period
// - Legacy 10 MHz clock never used
// - Bused triggers equal internal routes 0-7
// - Star only received, none in timing slot
// - Star selectable for AI, AO, counter
// - Star line A is clock input
// - Star line B is trigger input
// - Star line C is driven output
// - Transfers default to direct memory access
// - Programmed mode moves data per access
`timescale 1ns/1ps
module btd_top
	import btd_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite write address.
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	// AXI4-Lite write data.
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// AXI4-Lite read address.
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	// AXI4-Lite read data.
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// Backplane inputs.
	input  wire logic [NTRIG-1:0]  bp_trig,
	input  wire logic              bp_star,
	input  wire logic              bp_dstar_a,
	input  wire logic              bp_dstar_b,
	input  wire logic              in_timing_slot,
	// Backplane output.
	output logic                   bp_dstar_c,
	// Filtered signals to the device.
	output logic [NTRIG-1:0]       internal_trigger_route,
	output logic                   star_trig,
	output logic                   dstar_clk,
	output logic                   dstar_trig,
	output logic                   ai_ext_src,
	output logic                   ao_ext_src,
	output logic                   ctr_ext_src,
	// Transfer engine.
	output logic                   dma_en,
	input  wire logic [31:0]       pio_rdata,
	output logic                   pio_rd_stb,
	output logic [31:0]            pio_wdata,
	output logic                   pio_wr_stb
);
	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 aw_have;
		logic                 w_have;
		logic [ADDR_W-1:0]    awaddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic                 pio_mode;
		logic                 dma;
		logic [3:0]           dstarc_sel;
		logic                 dstarc_lvl;
		logic [3:0]           ai_sel;
		logic [3:0]           ao_sel;
		logic [3:0]           ctr_sel;
		logic [15:0]          cust_n;
		logic [15:0]          cust_d;
		logic [NCH-1:0][2:0]  fset;
		logic                 slot;
		logic [NCH-1:0]       filt_q;
		logic                 dstar_c;
		logic                 ai_src;
		logic                 ao_src;
		logic                 ctr_src;
		logic                 pio_rd;
		logic                 pio_wr;
		logic [31:0]          pio_wd;
	} btd_top_st_t;

	btd_top_st_t    st_r;
	btd_top_st_t    st_nxt;
	logic [NCH-1:0] raw;
	logic [NCH-1:0] filt;
	logic [31:0]    wcur;
	logic [31:0]    wnew;

	// ****************************************************************
	// Timebases and filters.
	// ****************************************************************
	btd_tick_if tb ();

	// Timebases come from aclk alone.
	// No backplane clock feeds them.
	btd_tick_div #(.W(16)) u_div_fast (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.div     (FAST_DIV),
		.tick    (tb.tick_fast)
	);

	btd_tick_div #(.W(16)) u_div_slow (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.div     (SLOW_DIV),
		.tick    (tb.tick_slow)
	);

	btd_tick_div #(.W(16)) u_div_cust (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.div     (st_r.cust_d),
		.tick    (tb.tick_cust)
	);

	assign tb.cust_n = st_r.cust_n;

	// Star input is dead while this module sits in the timing slot.
	// The pin gates the line directly.
	assign raw[NTRIG-1:0] = bp_trig;
	assign raw[CH_STAR]   = bp_star & ~in_timing_slot;
	assign raw[CH_DSTARA] = bp_dstar_a;
	assign raw[CH_DSTARB] = bp_dstar_b;

	for (genvar i = 0; i < NCH; i++) begin : g_flt
		btd_filter u_flt (
			.aclk    (aclk),
			.aresetn (aresetn),
			.ce      (ce),
			.setting (st_r.fset[i]),
			.tb      (tb),
			.din     (raw[i]),
			.dout    (filt[i])
		);
	end

	// ****************************************************************
	// Register helpers.
	// ****************************************************************
	// Selects past the last channel read low.
	function automatic logic pick(input logic [NCH-1:0] v, input logic [3:0] sel);
		pick = (int'(sel) < NCH) ? v[sel] : 1'b0;
	endfunction

	function automatic logic [31:0] rd_word(input btd_top_st_t s, input logic [7:0] a);
		rd_word = 32'h0000_0000;
		if (a == OFS_CTRL) begin
			rd_word = {23'h0, s.dstarc_lvl, s.dstarc_sel, 3'h0, s.pio_mode};
		end else if (a == OFS_ROUTE) begin
			rd_word = {20'h0, s.ctr_sel, s.ao_sel, s.ai_sel};
		end else if (a == OFS_CUST_N) begin
			rd_word = {16'h0, s.cust_n};
		end else if (a == OFS_CUST_D) begin
			rd_word = {16'h0, s.cust_d};
		end else if (a == OFS_STATUS) begin
			rd_word = {15'h0, s.slot, 5'h0, s.filt_q};
		end else if (a >= OFS_FILT0 && a < OFS_FILT0 + 8'(4 * NCH)) begin
			rd_word = {29'h0, s.fset[(a - OFS_FILT0) >> 2]};
		end
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= OFS_PIO ||
			(a >= OFS_FILT0 && a < OFS_FILT0 + 8'(4 * NCH)));
	endfunction

	// Bytes with a low strobe are kept.
	always_comb begin
		wcur = rd_word(st_r, st_r.awaddr);
		for (int b = 0; b < 4; b++) begin
			wnew[8*b +: 8] = st_r.wstrb[b] ? st_r.wdata[8*b +: 8] : wcur[8*b +: 8];
		end
	end

	// ****************************************************************
	// Next state.
	// ****************************************************************
	always_comb begin
		st_nxt        = st_r;
		st_nxt.slot   = in_timing_slot;
		st_nxt.filt_q = filt;
		st_nxt.pio_rd = 1'b0;
		st_nxt.pio_wr = 1'b0;

		// Write channel capture, address and data in either order.
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.wdata  = s_axi_wdata;
			st_nxt.wstrb  = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		// Both halves in hand: commit.
		// A zero custom count is stored as one.
		if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (st_r.awaddr == OFS_CTRL) begin
				st_nxt.pio_mode   = wnew[0];
				st_nxt.dstarc_sel = wnew[7:4];
				st_nxt.dstarc_lvl = wnew[8];
			end else if (st_r.awaddr == OFS_ROUTE) begin
				st_nxt.ai_sel  = wnew[3:0];
				st_nxt.ao_sel  = wnew[7:4];
				st_nxt.ctr_sel = wnew[11:8];
			end else if (st_r.awaddr == OFS_CUST_N) begin
				st_nxt.cust_n = (wnew[15:0] == 16'h0000) ? 16'h0001 : wnew[15:0];
			end else if (st_r.awaddr == OFS_CUST_D) begin
				st_nxt.cust_d = wnew[15:0];
			end else if (st_r.awaddr == OFS_PIO) begin
				st_nxt.pio_wd = st_r.wdata;
				st_nxt.pio_wr = st_r.pio_mode;
			end else if (mapped(st_r.awaddr) && st_r.awaddr >= OFS_FILT0) begin
				st_nxt.fset[(st_r.awaddr - OFS_FILT0) >> 2] = wnew[2:0];
			end
		end
		// A held half or a waiting response
		// refuses the next write.
		st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;

		// Read channel: one read in flight, answered the cycle after.
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			// Transfer port is live in programmed mode.
			// Otherwise a read returns zero.
			if (s_axi_araddr == OFS_PIO) begin
				st_nxt.rdata  = st_r.pio_mode ? pio_rdata : 32'h0000_0000;
				st_nxt.pio_rd = st_r.pio_mode;
			end else begin
				st_nxt.rdata = rd_word(st_r, s_axi_araddr);
			end
		end
		st_nxt.arready = !st_nxt.rvalid;

		// Output routing from the filtered lines.
		// Line C: software level or one line.
		st_nxt.dstar_c = (st_r.dstarc_sel == SEL_SWLVL) ? st_r.dstarc_lvl :
			pick(filt, st_r.dstarc_sel);
		st_nxt.ai_src  = pick(filt, st_r.ai_sel);
		st_nxt.ao_src  = pick(filt, st_r.ao_sel);
		st_nxt.ctr_src = pick(filt, st_r.ctr_sel);
		st_nxt.dma     = !st_nxt.pio_mode;
	end

	// Reset bypasses every filter.
	// A low ce freezes all, bus included.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r        <= '0;
			st_r.cust_n <= RST_CUST_N;
			st_r.cust_d <= RST_CUST_D;
			st_r.pio_mode <= 1'b0;
			st_r.dma      <= 1'b1;
			for (int i = 0; i < NCH; i++) begin
				st_r.fset[i] <= FS_NONE;
			end
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	// Outputs copy state bits.
	assign s_axi_awready          = st_r.awready;
	assign s_axi_wready           = st_r.wready;
	assign s_axi_bvalid           = st_r.bvalid;
	assign s_axi_bresp            = st_r.bresp;
	assign s_axi_arready          = st_r.arready;
	assign s_axi_rvalid           = st_r.rvalid;
	assign s_axi_rdata            = st_r.rdata;
	assign s_axi_rresp            = st_r.rresp;
	assign bp_dstar_c             = st_r.dstar_c;
	assign internal_trigger_route = st_r.filt_q[NTRIG-1:0];
	assign star_trig              = st_r.filt_q[CH_STAR];
	assign dstar_clk              = st_r.filt_q[CH_DSTARA];
	assign dstar_trig             = st_r.filt_q[CH_DSTARB];
	assign ai_ext_src             = st_r.ai_src;
	assign ao_ext_src             = st_r.ao_src;
	assign ctr_ext_src            = st_r.ctr_src;
	assign dma_en                 = st_r.dma;
	assign pio_rd_stb             = st_r.pio_rd;
	assign pio_wdata              = st_r.pio_wd;
	assign pio_wr_stb             = st_r.pio_wr;
endmodule

/* File: tb/btd_assertions.sv */
// Purpose: Concurrent checks on the ports of the trigger debounce block.
// Assumes: One aclk domain; ce held high by the bench.
// Notes:   Bypass checks hold only until software first writes a register.
`timescale 1ns/1ps
module btd_checker
	import btd_pkg::*;
(
	// Clock and reset.
	input wire logic             aclk,
	input wire logic             aresetn,
	// Register bus.
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [31:0]      s_axi_rdata,
	// Backplane lines.
	input wire logic [NTRIG-1:0] bp_trig,
	input wire logic             bp_dstar_a,
	input wire logic             bp_dstar_b,
	input wire logic             in_timing_slot,
	// Filtered lines and transfer engine.
	input wire logic [NTRIG-1:0] internal_trigger_route,
	input wire logic             star_trig,
	input wire logic             dstar_clk,
	input wire logic             dstar_trig,
	input wire logic             dma_en,
	input wire logic             pio_rd_stb,
	input wire logic             pio_wr_stb
);
	logic       wr_seen_r;
	logic [1:0] rst_hist_r;
	logic       calm;

	// Two clean edges after reset with no register write yet.
	assign calm = !wr_seen_r && (rst_hist_r == 2'h3);

	always_ff @(posedge aclk) begin
		rst_hist_r <= {rst_hist_r[0], aresetn};
		wr_seen_r  <= aresetn && (wr_seen_r || (s_axi_awvalid && s_axi_awready));
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	AST_PIO_RD: assert property (pio_rd_stb |-> $rose(s_axi_rvalid) && !dma_en) else $error("stray read strobe");
	AST_PIO_WR: assert property (pio_wr_stb |-> $rose(s_axi_bvalid) && !dma_en ##1 !pio_wr_stb) else $error("stray write strobe");
	AST_DMA_DEF: assert property (!wr_seen_r |-> dma_en) else $error("transfer mode not default");
	AST_BYPASS: assert property (calm |-> internal_trigger_route == $past(bp_trig, 2)) else $error("bused line not bypassed");
	AST_SLOT: assert property (calm && $past(in_timing_slot, 2) |-> !star_trig) else $error("star passed in timing slot");
	AST_DSTAR: assert property (calm |-> dstar_clk == $past(bp_dstar_a, 2) && dstar_trig == $past(bp_dstar_b, 2)) else $error("star lines not passed");
endmodule

bind btd_top btd_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.bp_trig(bp_trig), .bp_dstar_a(bp_dstar_a), .bp_dstar_b(bp_dstar_b),
	.in_timing_slot(in_timing_slot), .internal_trigger_route(internal_trigger_route),
	.star_trig(star_trig), .dstar_clk(dstar_clk), .dstar_trig(dstar_trig), .dma_en(dma_en),
	.pio_rd_stb(pio_rd_stb), .pio_wr_stb(pio_wr_stb));

/* File: tb/btd_backplane_model.sv */
// Purpose: Behavioural chassis backplane facing the trigger debounce block.
// Assumes: Lines are active-high levels synchronous to aclk.
// Notes:   The bench moves a line through set_line just after a rising edge.
`timescale 1ns/1ps
module btd_backplane_model (
	// Clock.
	input wire logic  aclk,
	// Lines towards the module.
	output logic [7:0] bp_trig,
	output logic       bp_star,
	output logic       bp_dstar_a,
	output logic       bp_dstar_b,
	output logic       in_timing_slot,
	// Line from the module.
	input wire logic   bp_dstar_c
);
	logic [11:0] line_r = 12'h000;
	logic        ref_clk100  = 1'b0;
	logic        ref_sync100 = 1'b0;

	assign bp_trig        = line_r[7:0];
	assign bp_star        = line_r[8];
	assign bp_dstar_a     = line_r[9];
	assign bp_dstar_b     = line_r[10];
	assign in_timing_slot = line_r[11];

	// Slot references that the block must never need.
	always #5 ref_clk100 = ~ref_clk100;
	always begin
		#90 ref_sync100 = 1'b1;
		#10 ref_sync100 = 1'b0;
	end

	task automatic set_all(input logic [11:0] val);
		line_r <= val;
	endtask

	task automatic set_line(input int idx, input logic val);
		line_r[idx] <= val;
	endtask
endmodule

/* File: tb/backplane_trigger_debounce_tb_top.sv */
// Purpose: Self-checking bench for the backplane trigger debounce block.
// Assumes: ce held high; backplane lines come from the model.
// Notes:   A sample index counts edges after the stimulus edge.
`timescale 1ns/1ps
module backplane_trigger_debounce_tb_top;
	import btd_pkg::*;
	logic aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_rd, ar_v, ar_r, r_v, r_rd;
	logic [7:0] aw_a, ar_a, route, trig;
	logic [31:0] w_d, rdata, pio_wd, pio_rdata;
	logic [1:0] bresp, rresp;
	logic star, dsa, dsb, slot, dsc, star_f, dclk, dtrig, ai, ao, ctr, dma, pio_rd, pio_wr;
	int num_errors, samples_checked, cycles, wr_pulses, rd_pulses;

	btd_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awvalid(aw_v),
		.s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_wvalid(w_v),
		.s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_bvalid(b_v),
		.s_axi_bready(b_rd), .s_axi_bresp(bresp), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_rvalid(r_v), .s_axi_rready(r_rd),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .bp_trig(trig), .bp_star(star),
		.bp_dstar_a(dsa), .bp_dstar_b(dsb), .in_timing_slot(slot), .bp_dstar_c(dsc),
		.internal_trigger_route(route), .star_trig(star_f), .dstar_clk(dclk),
		.dstar_trig(dtrig), .ai_ext_src(ai), .ao_ext_src(ao), .ctr_ext_src(ctr), .dma_en(dma),
		.pio_rdata(pio_rdata), .pio_rd_stb(pio_rd), .pio_wdata(pio_wd), .pio_wr_stb(pio_wr));
	btd_backplane_model bp (.aclk(aclk), .bp_trig(trig), .bp_star(star), .bp_dstar_a(dsa),
		.bp_dstar_b(dsb), .in_timing_slot(slot), .bp_dstar_c(dsc));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Strobe counters and the hang limit.
	always @(posedge aclk) begin
		cycles++;
		wr_pulses += pio_wr;
		rd_pulses += pio_rd;
		if (cycles > 20000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		aw_v <= 1'b1;
		aw_a <= a;
		w_v  <= 1'b1;
		w_d  <= d;
		b_rd <= 1'b1;
		do begin
			@(posedge aclk);
			if (aw_v && aw_r) aw_v <= 1'b0;
			if (w_v && w_r) w_v <= 1'b0;
		end while (!(b_v && b_rd));
		b_rd <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		ar_v <= 1'b1;
		ar_a <= a;
		r_rd <= 1'b1;
		do begin
			@(posedge aclk);
			if (ar_v && ar_r) ar_v <= 1'b0;
		end while (!(r_v && r_rd));
		r_rd <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	// Drives a pulse pattern on one line and counts filtered high samples.
	task automatic meas(input int ch, w1, g, w2, win, output int hits, first, ext);
		logic [10:0] v;
		hits = 0;
		first = -1;
		ext = 0;
		for (int i = 0; i < win; i++) begin
			@(posedge aclk);
			bp.set_line(ch, (i < w1) || (i >= w1 + g && i < w1 + g + w2));
			v = {dtrig, dclk, star_f, route};
			if (v[ch] === 1'b1) begin
				hits++;
				if (first < 0) first = i;
			end
			if ((ai & ao & ctr) === 1'b1) ext++;
		end
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		chk("dma_en", 1, dma);
		bp.set_all(12'hf01);
		rd(OFS_FILT0, d, r);
		chk("filt0", 0, d);
		rd(8'h48, d, r);
		chk("filt10", 0, d);
		rd(OFS_CUST_N, d, r);
		chk("cust_n", 9, d);
		rd(8'h1c, d, r);
		chk("unmapped resp", RESP_SLVERR, r);
		chk("reset route", 32'h1, route);
		chk("reset line a b", 32'h3, {dtrig, dclk});
		chk("reset slot star", 0, star_f);
		bp.set_all(12'h000);
		$display("test reset done");
	endtask

	task automatic t_filters();
		int h, f, e;
		wr(OFS_ROUTE, 32'h0000_0333);
		meas(3, 1, 0, 0, 8, h, f, e);
		chk("bypass hits", 1, h);
		chk("bypass delay", 3, f);
		chk("ext sources", 1, e);
		wr(OFS_FILT0, FS_SHORT);
		meas(0, 9, 0, 0, 30, h, f, e);
		chk("short delay", 11, f);
		chk("short hits", 9, h);
		meas(0, 8, 0, 0, 30, h, f, e);
		chk("short reject", 0, h);
		meas(0, 5, 1, 5, 30, h, f, e);
		chk("glitch restart", 0, h);
		wr(8'h44, FS_MEDIUM);
		meas(9, 512, 0, 0, 1100, h, f, e);
		chk("medium hits", 512, h);
		meas(9, 511, 0, 0, 600, h, f, e);
		chk("medium reject", 0, h);
		wr(8'h24, FS_HIGH);
		meas(1, 3000, 0, 0, 3100, h, f, e);
		chk("high reject", 0, h);
		$display("test filters done");
	endtask

	task automatic t_custom();
		int h, f, e;
		wr(OFS_CUST_N, 32'h4);
		wr(OFS_CUST_D, 32'h3);
		wr(8'h48, FS_CUSTOM);
		meas(10, 12, 0, 0, 60, h, f, e);
		chk("custom pass", 1, h > 0);
		chk("custom jitter", 1, f <= 18);
		meas(10, 6, 0, 0, 40, h, f, e);
		chk("custom reject", 0, h);
		meas(8, 1, 0, 0, 8, h, f, e);
		chk("star own setting", 1, h);
		$display("test custom done");
	endtask

	task automatic t_slot_io();
		int h, f, e;
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge aclk);
		bp.set_line(11, 1'b1);
		meas(8, 4, 0, 0, 10, h, f, e);
		chk("slot star", 0, h);
		rd(OFS_STATUS, d, r);
		chk("slot status", 1, d[16]);
		bp.set_line(11, 1'b0);
		wr(OFS_CTRL, 32'h1f0);
		repeat (2) @(posedge aclk);
		chk("line c high", 1, dsc);
		wr(OFS_CTRL, 32'h0f0);
		repeat (2) @(posedge aclk);
		chk("line c low", 0, dsc);
		wr(OFS_CTRL, 32'h1);
		repeat (2) @(posedge aclk);
		chk("pio mode", 0, dma);
		wr(OFS_PIO, 32'hc0de_0001);
		@(posedge aclk);
		chk("pio writes", 1, wr_pulses);
		chk("pio wdata", 32'hc0de_0001, pio_wd);
		rd(OFS_PIO, d, r);
		chk("pio rdata", pio_rdata, d);
		@(posedge aclk);
		chk("pio reads", 1, rd_pulses);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_PIO, 32'h1);
		@(posedge aclk);
		chk("dma no strobe", 1, wr_pulses);
		$display("test slot and transfer done");
	endtask

	initial begin
		{aresetn, aw_v, w_v, b_rd, ar_v, r_rd} = 6'h00;
		{aw_a, ar_a, w_d} = 48'h0;
		pio_rdata = 32'h5a5a_1234;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_filters();
		t_custom();
		t_slot_io();
		finish_test();
	end
endmodule
